// file: core/apcsd_map.vh
`ifndef APCSD_MAP_VH
`define APCSD_MAP_VH
`define APCSD_ADDR_DLY_EN 16'hFA26
`define APCSD_ADDR_DLY_SEL 16'hFA27
`define APCSD_ADDR_PIN_CFG 16'hFF8F
`define APCSD_ADDR_PORT_DIR 16'hFF22
`define APCSD_RST_PIN_CFG 8'h08
`define APCSD_RST_DLY_EN 8'h00
`define APCSD_RST_DLY_SEL 8'h20
`define APCSD_RST_PORT_DIR 8'hFF
`define APCSD_CFG_ALL_DIG 4'h8
`define APCSD_CFG_DSM_MAX 4'h4
`define APCSD_DLY_EN_BIT 7
`define APCSD_DLY_LSB 4
`define APCSD_DLY_MSB 6
`define APCSD_DLY_STEP_NS 2
`define APCSD_DLY_BASE_NS 2
`define APCSD_WAIT_CYCLES 1
`endif

// file: core/apcsd_pin_decode.v
`timescale 1ns/10ps
`include "apcsd_map.vh"
// per-pin analog/digital decode of the 4-bit configuration code
module apcsd_pin_decode #(
   parameter NPINS = 8
) (
   // configuration
   input wire [3:0] cfg,
   // decoded pin roles
   output wire [NPINS-1:0] analog,
   output wire [NPINS-1:0] dsm_ok
);
   wire legal = (cfg <= `APCSD_CFG_ALL_DIG);
   wire dsm_mode = (cfg <= `APCSD_CFG_DSM_MAX);
   genvar i;
   generate
      for (i = 0; i < NPINS; i = i + 1) begin : g_pin
         // pins below the code are digital; codes above all-digital get no analog role
         assign analog[i] = legal && ({28'h0, cfg} <= i); // [R1] [R2]
         // a pair serves the delta-sigma side only when both of its pins are analog
         assign dsm_ok[i] = legal && dsm_mode && ({28'h0, cfg} <= (i / 2) * 2); // [R1]
      end
   endgenerate
endmodule // apcsd_pin_decode

// file: core/apcsd_top.v
`timescale 1ns/10ps
`include "apcsd_map.vh"
// Functional notes
// [R1] decode pin code into analog/digital map
// [R2] codes above 1000 reserved, no function
// [R3] pin config resets 08H, upper nibble zero
// [R4] pin config takes bit and byte writes
// [R5] pin config write inserts one wait
// [R6] no pin writes with peripheral clock stopped
// [R7] software never selects digital pins for conversion
// [R8] delay enable bit7 at FA26H, reset 00H
// [R9] delay enable written only converter off
// [R10] delay field bits6:4 at FA27H, reset 20H
// [R11] delay written only when off and enabled
// [R12] direction bit 0 output, 1 input, FFH
// [R13] analog use needs direction bit set
// [R14] selected analog input routed to one converter; SAR and delta-sigma selects decode independently, so a pin can reach both
// [R15] direction takes bit and byte writes
// [R16] conversion enable and power bits pass through
module apcsd_top #(
   parameter NPINS = 8
) (
   // clock and reset
   input wire ref_clk,
   input wire srst,
   // processor access
   input wire [15:0] cpu_addr,
   input wire cpu_wr,
   input wire cpu_rd,
   input wire cpu_bit_op,
   input wire [2:0] cpu_bit_idx,
   input wire [7:0] cpu_wdata,
   output wire [7:0] cpu_rdata,
   output wire cpu_wait,
   // converter unit
   input wire dsm_power_on,
   input wire dsm_conversion_enable,
   input wire [2:0] sar_channel_select,
   input wire [1:0] dsm_channel_select,
   // pin routing
   output wire [NPINS-1:0] pin_analog,
   output wire [NPINS-1:0] pin_out_en,
   output wire [NPINS-1:0] sar_route,
   output wire [NPINS-1:0] dsm_route,
   output wire [2:0] sample_delay,
   output wire delay_set_enable,
   output reg dsm_power_q,
   output reg dsm_conv_q
);

   // reset values as vectors so each field can be picked by position
   wire [7:0] rst_pin_cfg = `APCSD_RST_PIN_CFG;
   wire [7:0] rst_port_dir = `APCSD_RST_PORT_DIR;
   wire [7:0] rst_dly_en = `APCSD_RST_DLY_EN;
   wire [7:0] rst_dly_sel = `APCSD_RST_DLY_SEL;

   // pins 6 and 7 carry the reference, the delta-sigma pairs stop below them
   localparam DSM_PINS = 6;

   // one-hot states of the write stall sequencer
   localparam [1:0] ST_IDLE = 2'h1;
   localparam [1:0] ST_STALL = 2'h2;

   // register contents
   reg [3:0] pin_cfg_q;
   reg [3:0] pin_cfg_d;
   reg [7:0] port_dir_q;
   reg [7:0] port_dir_d;
   reg dly_en_q;
   reg dly_en_d;
   reg [2:0] dly_q;
   reg [2:0] dly_d;
   reg [1:0] state_q;
   reg [1:0] state_d;
   reg cfg_commit;

   // output flops
   reg [7:0] cpu_rdata_q;
   reg [7:0] cpu_rdata_d;
   reg cpu_wait_q;
   reg cpu_wait_d;
   reg [NPINS-1:0] pin_analog_q;
   reg [NPINS-1:0] pin_out_en_q;
   reg [NPINS-1:0] sar_route_q;
   reg [NPINS-1:0] dsm_route_q;
   reg [2:0] sample_delay_q;
   reg delay_set_enable_q;

   // per-pin next values
   wire [NPINS-1:0] ana;
   wire [NPINS-1:0] dsm_ok;
   wire [NPINS-1:0] pin_analog_d;
   wire [NPINS-1:0] pin_out_en_d;
   wire [NPINS-1:0] sar_route_d;
   wire [NPINS-1:0] dsm_route_d;

   // address decode
   wire sel_cfg = (cpu_addr == `APCSD_ADDR_PIN_CFG);
   wire sel_dir = (cpu_addr == `APCSD_ADDR_PORT_DIR);
   wire sel_en = (cpu_addr == `APCSD_ADDR_DLY_EN);
   wire sel_dly = (cpu_addr == `APCSD_ADDR_DLY_SEL);
   wire [7:0] bit_mask = 8'h01 << cpu_bit_idx;

   apcsd_pin_decode #(.NPINS(NPINS)) u_dec (
      .cfg(pin_cfg_q),
      .analog(ana),
      .dsm_ok(dsm_ok)
   );

   // merged write data: bit ops modify one bit of the current value
   function [7:0] merge;
      input [7:0] cur;
      begin
         if (cpu_bit_op) begin
            merge = (cur & ~bit_mask) | (cpu_wdata & bit_mask);
         end else begin
            merge = cpu_wdata;
         end
      end
   endfunction

   wire [7:0] cfg_new = merge({4'h0, pin_cfg_q});
   wire [7:0] dir_new = merge(port_dir_q);
   // converter must be off for delay writes; guards against mid-conversion glitches
   wire dsm_idle = !dsm_power_on && !dsm_conversion_enable; // [R9]

   // the stall lasts one cycle; a write held longer counts as a second write
   always @* begin
      state_d = state_q;
      cpu_wait_d = 1'b0;
      cfg_commit = 1'b0;
      case (state_q)
         ST_IDLE: begin
            if (cpu_wr && sel_cfg) begin
               state_d = ST_STALL;
               cpu_wait_d = 1'b1; // [R5]
            end
         end
         ST_STALL: begin
            // the write lands on the edge that ends the wait cycle
            cfg_commit = cpu_wr && sel_cfg; // [R5]
            state_d = ST_IDLE;
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   // register writes
   always @* begin
      pin_cfg_d = pin_cfg_q;
      port_dir_d = port_dir_q;
      dly_en_d = dly_en_q;
      dly_d = dly_q;
      if (cfg_commit) begin
         pin_cfg_d = cfg_new[3:0]; // [R4] [R3]
      end
      if (cpu_wr && sel_dir) begin
         port_dir_d = dir_new; // [R15]
      end
      // delay registers take byte writes only
      if (cpu_wr && !cpu_bit_op && sel_en && dsm_idle) begin
         dly_en_d = cpu_wdata[`APCSD_DLY_EN_BIT]; // [R8] [R9]
      end
      if (cpu_wr && !cpu_bit_op && sel_dly && dsm_idle && dly_en_q) begin
         dly_d = cpu_wdata[`APCSD_DLY_MSB:`APCSD_DLY_LSB]; // [R10] [R11]
      end
   end

   // read data: unmapped addresses and idle cycles read zero
   always @* begin
      cpu_rdata_d = 8'h00;
      if (cpu_rd) begin
         case (cpu_addr)
            `APCSD_ADDR_PIN_CFG: cpu_rdata_d = {4'h0, pin_cfg_q}; // [R3]
            `APCSD_ADDR_PORT_DIR: cpu_rdata_d = port_dir_q;
            `APCSD_ADDR_DLY_EN: cpu_rdata_d = {dly_en_q, 7'h00}; // [R8]
            `APCSD_ADDR_DLY_SEL: cpu_rdata_d = {1'b0, dly_q, 4'h0}; // [R10]
            default: cpu_rdata_d = 8'h00;
         endcase
      end
   end

   genvar p;
   generate
      for (p = 0; p < NPINS; p = p + 1) begin : g_route
         assign pin_analog_d[p] = ana[p]; // [R1]
         // output buffer only for digital pins in output mode
         assign pin_out_en_d[p] = !ana[p] && !port_dir_q[p]; // [R12] [R13]
         // route only analog inputs; a pin in output mode is never converted
         assign sar_route_d[p] = ana[p] && port_dir_q[p]
            && ({29'h0, sar_channel_select} == p); // [R14]
         assign dsm_route_d[p] = dsm_ok[p] && port_dir_q[p] && (p < DSM_PINS)
            && ({30'h0, dsm_channel_select} == p / 2); // [R14]
      end
   endgenerate

   always @(posedge ref_clk) begin
      if (srst) begin
         state_q <= ST_IDLE;
         pin_cfg_q <= rst_pin_cfg[3:0]; // [R3]
         port_dir_q <= rst_port_dir; // [R12]
         dly_en_q <= rst_dly_en[`APCSD_DLY_EN_BIT]; // [R8]
         dly_q <= rst_dly_sel[`APCSD_DLY_MSB:`APCSD_DLY_LSB]; // [R10]
      end else begin
         state_q <= state_d;
         pin_cfg_q <= pin_cfg_d;
         port_dir_q <= port_dir_d;
         dly_en_q <= dly_en_d;
         dly_q <= dly_d;
      end
   end

   always @(posedge ref_clk) begin
      if (srst) begin
         cpu_rdata_q <= 8'h00;
         cpu_wait_q <= 1'b0;
         pin_analog_q <= {NPINS{1'b0}};
         pin_out_en_q <= {NPINS{1'b0}};
         sar_route_q <= {NPINS{1'b0}};
         dsm_route_q <= {NPINS{1'b0}};
         sample_delay_q <= rst_dly_sel[`APCSD_DLY_MSB:`APCSD_DLY_LSB];
         delay_set_enable_q <= rst_dly_en[`APCSD_DLY_EN_BIT];
         dsm_power_q <= 1'b0;
         dsm_conv_q <= 1'b0;
      end else begin
         cpu_rdata_q <= cpu_rdata_d;
         cpu_wait_q <= cpu_wait_d; // [R5]
         pin_analog_q <= pin_analog_d;
         pin_out_en_q <= pin_out_en_d;
         sar_route_q <= sar_route_d;
         dsm_route_q <= dsm_route_d;
         sample_delay_q <= dly_q;
         delay_set_enable_q <= dly_en_q;
         dsm_power_q <= dsm_power_on; // [R16]
         dsm_conv_q <= dsm_conversion_enable; // [R16]
      end
   end

   // every output is a flop; the ports only rename them
   assign cpu_rdata = cpu_rdata_q;
   assign cpu_wait = cpu_wait_q;
   assign pin_analog = pin_analog_q;
   assign pin_out_en = pin_out_en_q;
   assign sar_route = sar_route_q;
   assign dsm_route = dsm_route_q;
   assign sample_delay = sample_delay_q;
   assign delay_set_enable = delay_set_enable_q;
endmodule // apcsd_top

// file: testbench/apcsd_properties.sv
`timescale 1ns/10ps
module apcsd_chk #(
   parameter NPINS = 8
) (
   // clock and reset
   input logic ref_clk,
   input logic srst,
   // processor access
   input logic [15:0] cpu_addr,
   input logic cpu_wr,
   input logic cpu_wait,
   // routing and delay
   input logic [NPINS-1:0] pin_analog,
   input logic [NPINS-1:0] sar_route,
   input logic [NPINS-1:0] dsm_route,
   input logic [2:0] sample_delay,
   input logic delay_set_enable
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (srst);
   a_cfg_wait: assert property (cpu_wr && cpu_addr == 16'hFF8F && !cpu_wait |=> cpu_wait)
      else $error("no wait");
   a_wait_single: assert property (cpu_wait |=> !cpu_wait) else $error("long wait");
   a_wait_cause: assert property ($rose(cpu_wait) |-> $past(cpu_wr) && $past(cpu_addr) == 16'hFF8F)
      else $error("stray wait");
   a_analog_top: assert property ((pin_analog[6:0] & ~pin_analog[7:1]) == 0)
      else $error("analog map");
   a_route_analog: assert property (((sar_route | dsm_route) & ~pin_analog) == 0)
      else $error("digital pin routed");
   a_dsm_codes: assert property (dsm_route != 0 |-> &pin_analog[5:4] && !dsm_route[7:6])
      else $error("dsm route");
   a_en_by_write: assert property ($changed(delay_set_enable) |-> $past(cpu_wr, 2) && $past(cpu_addr, 2) == 16'hFA26)
      else $error("enable changed");
   a_dly_gated: assert property ($changed(sample_delay) |-> $past(delay_set_enable, 2))
      else $error("delay changed");
   c_wait: cover property (cpu_wait);
   c_dsm: cover property (dsm_route != 0);
   c_dly: cover property ($changed(sample_delay));
endmodule // apcsd_chk
bind apcsd_top apcsd_chk #(.NPINS(NPINS)) u_chk (
   .ref_clk(ref_clk),
   .srst(srst),
   .cpu_addr(cpu_addr),
   .cpu_wr(cpu_wr),
   .cpu_wait(cpu_wait),
   .pin_analog(pin_analog),
   .sar_route(sar_route),
   .dsm_route(dsm_route),
   .sample_delay(sample_delay),
   .delay_set_enable(delay_set_enable)
);

// file: testbench/testbench.sv
`timescale 1ns/10ps
module testbench;
   logic ref_clk = 0, srst = 1, cpu_wr = 0, cpu_rd = 0, cpu_bit_op = 0, cpu_wait;
   logic dsm_power_on = 0, dsm_conversion_enable = 0, delay_set_enable, dsm_power_q, dsm_conv_q;
   logic [15:0] cpu_addr = 0;
   logic [2:0] cpu_bit_idx = 0, sar_channel_select = 0, sample_delay;
   logic [1:0] dsm_channel_select = 0;
   logic [7:0] cpu_wdata = 0, cpu_rdata, pin_analog, pin_out_en, sar_route, dsm_route, r;
   int error_cnt = 0, checks_done = 0;
   apcsd_top u_dut (
      .ref_clk(ref_clk),
      .srst(srst),
      .cpu_addr(cpu_addr),
      .cpu_wr(cpu_wr),
      .cpu_rd(cpu_rd),
      .cpu_bit_op(cpu_bit_op),
      .cpu_bit_idx(cpu_bit_idx),
      .cpu_wdata(cpu_wdata),
      .cpu_rdata(cpu_rdata),
      .cpu_wait(cpu_wait),
      .dsm_power_on(dsm_power_on),
      .dsm_conversion_enable(dsm_conversion_enable),
      .sar_channel_select(sar_channel_select),
      .dsm_channel_select(dsm_channel_select),
      .pin_analog(pin_analog),
      .pin_out_en(pin_out_en),
      .sar_route(sar_route),
      .dsm_route(dsm_route),
      .sample_delay(sample_delay),
      .delay_set_enable(delay_set_enable),
      .dsm_power_q(dsm_power_q),
      .dsm_conv_q(dsm_conv_q)
   );
   // the clock never stops, so a pin config wait cycle always completes
   always #5 ref_clk = ~ref_clk;
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // held two edges: a pin config write needs the wait cycle
   task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic b = 0,
         input logic [2:0] i = 0);
      cpu_addr <= a;
      cpu_wdata <= d;
      cpu_bit_op <= b;
      cpu_bit_idx <= i;
      cpu_wr <= 1;
      repeat (2) @(posedge ref_clk);
      if (a == 16'hFF8F) chk({7'h0, cpu_wait}, 8'h01);
      cpu_wr <= 0;
      repeat (2) @(posedge ref_clk);
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      cpu_addr <= a;
      cpu_rd <= 1;
      @(posedge ref_clk);
      cpu_rd <= 0;
      @(posedge ref_clk);
      chk(cpu_rdata, e);
   endtask
   function automatic logic [7:0] amask(input int c);
      return 8'hFF << c;
   endfunction
   task automatic final_report;
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      void'($urandom(32'h557207EB));
      repeat (10) @(posedge ref_clk);
      srst <= 0;
      @(posedge ref_clk);
      rd(16'hFF8F, 8'h08);
      rd(16'hFA26, 8'h00);
      rd(16'hFA27, 8'h20);
      rd(16'hFF22, 8'hFF);
      rd(16'h0000, 8'h00);
      for (int c = 0; c <= 8; c++) begin
         wr(16'hFF8F, {4'($urandom), 4'(c)});
         rd(16'hFF8F, 8'(c));
         chk(pin_analog, amask(c));
      end
      r = 8'($urandom);
      wr(16'hFF22, r);
      chk(pin_out_en, ~r);
      wr(16'hFF22, 8'h08, 1, 3);
      rd(16'hFF22, r | 8'h08);
      wr(16'hFF22, 8'hFF);
      wr(16'hFF8F, 8'h00, 1, 3);
      rd(16'hFF8F, 8'h00);
      $display("pin config test done");
      r = 8'(2 + $urandom % 6);
      sar_channel_select <= r[2:0];
      repeat (3) @(posedge ref_clk);
      chk(sar_route, 8'h01 << r);
      chk(dsm_route, 8'h03);
      sar_channel_select <= 3'h7;
      dsm_channel_select <= 2'h1;
      wr(16'hFF8F, 8'h02);
      chk(dsm_route, 8'h0C);
      chk(sar_route, 8'h80);
      wr(16'hFF8F, 8'h05);
      chk(dsm_route, 8'h00);
      chk(sar_route, 8'h80);
      $display("routing test done");
      dsm_power_on <= 1;
      wr(16'hFA27, 8'h50);
      rd(16'hFA27, 8'h20);
      wr(16'hFA26, 8'h80);
      rd(16'hFA26, 8'h00);
      chk({7'h0, dsm_power_q}, 8'h01);
      dsm_power_on <= 0;
      @(posedge ref_clk);
      wr(16'hFA26, 8'hFF);
      rd(16'hFA26, 8'h80);
      r = 8'($urandom);
      wr(16'hFA27, r);
      rd(16'hFA27, r & 8'h70);
      chk({5'h0, sample_delay}, {5'h0, r[6:4]});
      dsm_conversion_enable <= 1;
      wr(16'hFA26, 8'h00);
      rd(16'hFA26, 8'h80);
      wr(16'hFA27, 8'h00);
      rd(16'hFA27, r & 8'h70);
      chk({7'h0, dsm_conv_q}, 8'h01);
      dsm_conversion_enable <= 0;
      $display("delay test done");
      final_report;
   end
endmodule // testbench
